// [testbench/bridge_control_chk.sv]
/* Port checker of bridge_control: interrupt pin, soft reset pulse, idle
   outputs and lane decode. Assumes a bind onto bridge_control. */
`default_nettype none
module bridge_control_chk #(parameter LANES = 4, parameter LANE_BITS = 7) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic [LANES*LANE_BITS-1:0] lvds_a_out,
  input wire logic [LANES*LANE_BITS-1:0] lvds_b_out,
  input wire logic lvds_strobe_out,
  input wire logic pll_enable_out,
  input wire logic soft_reset_out,
  input wire logic [3:0] chan_a_lane_enable_out,
  input wire logic irq_out,
  input wire logic irq_oe_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic srst_req_q;
  // Soft reset request one edge back, so the pulse can be tied to it
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      srst_req_q <= 1'b0;
    end else begin
      srst_req_q <= reg_wr_in && reg_addr_in == 8'h09 && reg_wdata_in[0];
    end
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  AST_IRQ_NEEDS_OE: assert property (irq_out |-> irq_oe_out)
    else $error("irq high while pin released");
  AST_OE_ON: assert property (reg_wr_in && reg_addr_in == 8'hE0 && reg_wdata_in[0]
    |-> ##[1:2] irq_oe_out) else $error("pin not driven after enable");
  AST_OE_OFF: assert property (reg_wr_in && reg_addr_in == 8'hE0 && !reg_wdata_in[0]
    |-> ##2 !irq_oe_out && !irq_out) else $error("irq left on after disable");
  AST_IDLE: assert property (!pll_enable_out [*3]
    |-> lvds_a_out == '0 && lvds_b_out == '0 && !lvds_strobe_out) else $error("outputs live");
  AST_STROBE_LIVE: assert property (lvds_strobe_out |-> pll_enable_out || $past(pll_enable_out))
    else $error("strobe without pll");
  AST_SRST_PULSE: assert property (srst_req_q |-> soft_reset_out ##1 !soft_reset_out)
    else $error("soft reset pulse wrong");
  AST_SRST_CAUSE: assert property (soft_reset_out |-> srst_req_q)
    else $error("soft reset without request");
  AST_LANES_ALL: assert property (reg_wr_in && reg_addr_in == 8'h10
    && reg_wdata_in[4:3] == 2'h0 |-> ##2 chan_a_lane_enable_out == 4'hF) else $error("lanes bad");
endmodule
`default_nettype wire

// [testbench/host_link_model.sv]
/* Host side model: free-running lane clock, stream flag and lane words.
   Assumes run_in comes from the bench on the system clock. */
`default_nettype none
module host_link_model #(
  parameter int HALF_NS = 370,
  parameter logic [27:0] A_WORD = 28'h0,
  parameter logic [27:0] B_WORD = 28'h0
) (
  input wire logic run_in,
  output logic clk_lane_out,
  output logic active_out,
  output logic [27:0] a_word_out,
  output logic [27:0] b_word_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Clock lane stays in high-speed mode even while video is stopped
  initial begin
    clk_lane_out = 1'b0;
    forever #(HALF_NS) clk_lane_out = ~clk_lane_out;
  end
  // Data lanes rest at the all-ones idle state outside a stream
  assign active_out = run_in;
  assign a_word_out = run_in ? A_WORD : '1;
  assign b_word_out = run_in ? B_WORD : '1;
endmodule
`default_nettype wire

// [testbench/tb_bridge_control.sv]
/* Self-checking bench of bridge_control and its host link model.
   Assumes design, checker and model compile first. */
`default_nettype none
module tb_bridge_control;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF = 370;
  localparam logic [27:0] AW = {7'h04, 7'h03, 7'h02, 7'h01};
  localparam logic [27:0] BW = {7'h44, 7'h33, 7'h22, 7'h11};
  logic clk_sys_in = 1'b0, nrst_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic reference_clock_input = 1'b0, pll_lock_in = 1'b0, run = 1'b0;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
  logic [5:0] chan_a_err_in = 6'h00, chan_b_err_in = 6'h00;
  logic reg_rvalid_out, hs_clock_lane_in, stream_active_in, lvds_strobe_out;
  logic pll_enable_out, soft_reset_out, irq_out, irq_oe_out;
  logic [27:0] chan_a_word_in, chan_b_word_in, lvds_a_out, lvds_b_out, sa, sb;
  logic [3:0] chan_a_lane_enable_out;
  logic [2:0] out_clock_range_out;
  logic [7:0] chan_a_input_clock_range_out;
  int error_cnt = 0, n_compared = 0, cyc = 0, c, e;
  // Ordinary register cases: offset, write value, value read back
  logic [7:0] rows [8][3] = '{'{8'h0A, 8'h05, 8'h05}, '{8'h0B, 8'h28, 8'h28},
    '{8'h12, 8'h62, 8'h62}, '{8'h10, 8'h00, 8'h00}, '{8'hE1, 8'hFC, 8'hFC},
    '{8'hE2, 8'hFC, 8'hFC}, '{8'h09, 8'h01, 8'h00}, '{8'h77, 8'hAA, 8'h00}};
  logic [7:0] ord [5] = '{8'h20, 8'h10, 8'h40, 8'h70, 8'h00};

  bridge_control i_bridge_control (.*);
  host_link_model #(.HALF_NS(HALF), .A_WORD(AW), .B_WORD(BW)) i_host_link_model (
    .run_in(run), .clk_lane_out(hs_clock_lane_in), .active_out(stream_active_in),
    .a_word_out(chan_a_word_in), .b_word_out(chan_b_word_in));

  initial begin
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  // Reference clock at an eighth of the system rate; also the hang guard
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    reference_clock_input <= cyc[2];
    if (cyc == 40000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("errors=%0d compared=%0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] x);
    n_compared++;
    if (g !== x) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic chkw(input logic [27:0] g, input logic [27:0] x);
    n_compared++;
    if (g !== x) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask
  // Read answer is looked at just after the edge that launches it
  task automatic rdchk(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1;
    chk8(reg_rvalid_out === 1'b1 ? reg_rdata_out : 8'hXX, x);
  endtask
  task automatic clr();
    wr(8'hE5, 8'hFF);
    wr(8'hE6, 8'hFF);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic pulse(input logic [5:0] a, input logic [5:0] b);
    @(posedge clk_sys_in);
    chan_a_err_in <= a;
    chan_b_err_in <= b;
    @(posedge clk_sys_in);
    chan_a_err_in <= 6'h00;
    chan_b_err_in <= 6'h00;
  endtask
  // Cycles from one strobe through five more; bounded only after the first strobe, so a dead path waits for the hang guard
  task automatic gap(output int n);
    int s = 0;
    n = 0;
    while (s < 6 && n < 2000) begin
      @(posedge clk_sys_in);
      #1;
      if (lvds_strobe_out === 1'b1) s++;
      if (s > 0) n++;
    end
  endtask
  function automatic logic [27:0] rev(input logic [27:0] w);
    return {w[6:0], w[13:7], w[20:14], w[27:21]};
  endfunction

  initial begin
    repeat (2) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    rdchk(8'hE5, 8'h01);
    chk8({4'h0, chan_a_lane_enable_out}, 8'h0F);
    for (int i = 0; i < 8; i++) begin
      wr(rows[i][0], rows[i][1]);
      rdchk(rows[i][0], rows[i][2]);
    end
    chk8({5'h00, out_clock_range_out}, 8'h02);
    chk8(chan_a_input_clock_range_out, 8'h62);
    wr(8'hE5, 8'h01);
    rdchk(8'hE5, 8'h00);
    // Every error kind on both channels; a zero write must not clear
    for (int i = 0; i < 6; i++) begin
      pulse(6'(1 << i), 6'(1 << i));
      wr(8'hE5, 8'h00);
      rdchk(8'hE5, 8'(4 << i));
      rdchk(8'hE6, 8'(4 << i));
      clr();
    end
    rdchk(8'hE5, 8'h00);
    pulse(6'h20, 6'h00);
    wr(8'hE0, 8'h01);
    settle(3);
    chk8({6'h00, irq_oe_out, irq_out}, 8'h03);
    wr(8'hE1, 8'h00);
    settle(3);
    chk8({6'h00, irq_oe_out, irq_out}, 8'h02);
    wr(8'hE1, 8'hFC);
    wr(8'hE0, 8'h00);
    settle(3);
    chk8({6'h00, irq_oe_out, irq_out}, 8'h00);
    wr(8'hE5, 8'hFF);
    // Restart order: stream, pll, settle time, then soft reset
    @(posedge clk_sys_in);
    run <= 1'b1;
    pll_lock_in <= 1'b1;
    wr(8'h0D, 8'h01);
    repeat (30000) @(posedge clk_sys_in);
    wr(8'h09, 8'h01);
    rdchk(8'hE5, 8'h08);
    rdchk(8'hE6, 8'h08);
    clr();
    // Lane clock: divide by six, then code zero
    for (int i = 0; i < 2; i++) begin
      wr(8'h0B, i ? 8'h00 : 8'h28);
      gap(c);
      e = (i ? 1 : 6) * 2 * HALF * 5 / 100 + 1;
      chk8(8'((c - e) * (c - e) <= 1), 8'h01);
    end
    wr(8'h0A, 8'h04);
    gap(c);
    chk8(8'(c), 8'h29);
    foreach (ord[i]) begin
      wr(8'h1A, ord[i]);
      settle(4);
      sa = ord[i][6] ? BW : AW;
      sb = ord[i][6] ? AW : BW;
      chkw(lvds_a_out, ord[i][5] ? rev(sa) : sa);
      chkw(lvds_b_out, ord[i][4] ? rev(sb) : sb);
    end
    wr(8'h21, 8'h00);
    wr(8'h38, 8'h00);
    wr(8'h2C, 8'hFF);
    wr(8'h3C, 8'h10);
    settle(4);
    chkw(lvds_a_out, 28'h1000000);
    @(posedge clk_sys_in);
    pll_lock_in <= 1'b0;
    settle(8);
    chkw(lvds_a_out, 28'h0000000);
    rdchk(8'hE5, 8'h01);
    // Stop order: pll off first, then the stream halts
    wr(8'h0D, 8'h00);
    @(posedge clk_sys_in);
    run <= 1'b0;
    settle(8);
    rdchk(8'hE5, 8'h09);
    rdchk(8'hE6, 8'h08);
    clr();
    rdchk(8'hE6, 8'h00);
    print_verdict();
  end
endmodule
bind bridge_control bridge_control_chk #(.LANES(LANES), .LANE_BITS(LANE_BITS))
  i_bridge_control_chk (.*);
`default_nettype wire

// [verilog/bridge_control.v]
/*
  Control logic of a two-channel serial video to LVDS bridge:
  registers, PLL enable, soft reset, pixel clock source and divider,
  test pattern, lane reversal, channel swap and interrupt pin.
  Assumes the register port and error pulses come from logic on clk_sys_in;
  clock lanes, PLL lock and stream activity arrive as asynchronous pins.
*/
`default_nettype none
`include "bridge_ctrl_defines.vh"
module bridge_control #(
  parameter LANES = 4,
  parameter LANE_BITS = 7
) (
  input wire clk_sys_in,
  input wire nrst_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [7:0] reg_rdata_out,
  output reg reg_rvalid_out,
  input wire hs_clock_lane_in,
  input wire reference_clock_input,
  input wire pll_lock_in,
  input wire stream_active_in,
  input wire [5:0] chan_a_err_in,
  input wire [5:0] chan_b_err_in,
  input wire [LANES*LANE_BITS-1:0] chan_a_word_in,
  input wire [LANES*LANE_BITS-1:0] chan_b_word_in,
  output reg [LANES*LANE_BITS-1:0] lvds_a_out,
  output reg [LANES*LANE_BITS-1:0] lvds_b_out,
  output reg lvds_strobe_out,
  output reg pll_enable_out,
  output reg soft_reset_out,
  output reg [3:0] chan_a_lane_enable_out,
  output reg [2:0] out_clock_range_out,
  output reg [7:0] chan_a_input_clock_range_out,
  output reg irq_out,
  output reg irq_oe_out
);
  localparam W = LANES * LANE_BITS;

  // Configuration registers
  reg [7:0] output_clock_config_reg;
  reg [7:0] clock_divider_config_reg;
  reg [7:0] pll_control_reg;
  reg [7:0] chan_cfg_reg;
  reg [7:0] input_clock_range_reg;
  reg [7:0] lane_order_control_reg;
  reg [7:0] line_len_lo_reg;
  reg [7:0] line_len_hi_reg;
  reg [7:0] vsize_lo_reg;
  reg [7:0] vsize_hi_reg;
  reg [7:0] hsync_width_reg;
  reg [7:0] vsync_width_reg;
  reg [7:0] hback_reg;
  reg [7:0] vback_reg;
  reg [7:0] hfront_reg;
  reg [7:0] vfront_reg;
  reg [7:0] test_pattern_control_reg;
  reg [7:0] interrupt_output_enable_reg;
  reg [7:0] chan_a_error_mask_reg;
  reg [7:0] chan_b_error_mask_reg;
  reg [7:0] cha_status_reg;
  reg [7:0] chb_status_reg;
  reg [7:0] cha_status_next;
  reg [7:0] chb_status_next;
  reg [7:0] rdata_next;

  // Synchronised pins and edge history
  wire hs_lvl;
  wire ref_lvl;
  wire lock_lvl;
  wire stream_lvl;
  reg hs_prev_reg;
  reg ref_prev_reg;
  reg lock_prev_reg;
  reg stream_prev_reg;
  wire pixel_tick;
  wire src_edge;
  wire [4:0] ratio_code;
  wire wr_soft_reset;
  wire output_live;

  sync_agree u_sync_hs (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .async_in(hs_clock_lane_in),
    .level_out(hs_lvl)
  );
  sync_agree u_sync_ref (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .async_in(reference_clock_input),
    .level_out(ref_lvl)
  );
  sync_agree u_sync_lock (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .async_in(pll_lock_in),
    .level_out(lock_lvl)
  );
  sync_agree u_sync_stream (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .async_in(stream_active_in),
    .level_out(stream_lvl)
  );

  // Edge history of the agreed pin levels
  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hs_prev_reg <= 1'b0;
      ref_prev_reg <= 1'b0;
      lock_prev_reg <= 1'b0;
      stream_prev_reg <= 1'b0;
    end else begin
      hs_prev_reg <= hs_lvl;
      ref_prev_reg <= ref_lvl;
      lock_prev_reg <= lock_lvl;
      stream_prev_reg <= stream_lvl;
    end
  end

  // Source select picks the continuous lane clock or the reference clock;
  // the reference path is passed at its own rate (see R16)
  assign src_edge = output_clock_config_reg[`BIT_CLK_SRC_SEL] ? (hs_lvl & ~hs_prev_reg)
    : (ref_lvl & ~ref_prev_reg);
  assign ratio_code = output_clock_config_reg[`BIT_CLK_SRC_SEL] ?
                      clock_divider_config_reg[`DIV_MSB:`DIV_LSB] : 5'h00; // see R11
  assign wr_soft_reset = reg_wr_in && (reg_addr_in == `OFS_SOFT_RESET) &&
                         reg_wdata_in[`BIT_SOFT_RESET];
  // PLL enabled and locked before anything leaves the pins (see R24)
  assign output_live = pll_control_reg[`BIT_PLL_EN] & lock_lvl;

  pixel_divider u_div (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .restart_in(soft_reset_out),
    .edge_in(src_edge),
    .ratio_code_in(ratio_code),
    .tick_out(pixel_tick)
  );

  // Register writes; soft reset is a strobe, never stored (see R23)
  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      output_clock_config_reg <= `RST_ZERO;
      clock_divider_config_reg <= `RST_ZERO;
      pll_control_reg <= `RST_ZERO;
      chan_cfg_reg <= `RST_ZERO;
      input_clock_range_reg <= `RST_ZERO;
      lane_order_control_reg <= `RST_ZERO;
      line_len_lo_reg <= `RST_ZERO;
      line_len_hi_reg <= `RST_ZERO;
      vsize_lo_reg <= `RST_ZERO;
      vsize_hi_reg <= `RST_ZERO;
      hsync_width_reg <= `RST_ZERO;
      vsync_width_reg <= `RST_ZERO;
      hback_reg <= `RST_ZERO;
      vback_reg <= `RST_ZERO;
      hfront_reg <= `RST_ZERO;
      vfront_reg <= `RST_ZERO;
      test_pattern_control_reg <= `RST_ZERO;
      interrupt_output_enable_reg <= `RST_ZERO;
      chan_a_error_mask_reg <= `RST_ZERO;
      chan_b_error_mask_reg <= `RST_ZERO;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `OFS_OUT_CLK_CFG: output_clock_config_reg <= reg_wdata_in;
        `OFS_CLK_DIV_CFG: clock_divider_config_reg <= reg_wdata_in;
        `OFS_PLL_CTRL: pll_control_reg <= reg_wdata_in;
        `OFS_CHAN_CFG: chan_cfg_reg <= reg_wdata_in;
        `OFS_IN_CLK_RANGE: input_clock_range_reg <= reg_wdata_in;
        `OFS_LANE_ORDER: lane_order_control_reg <= reg_wdata_in;
        `OFS_LINE_LEN_LO: line_len_lo_reg <= reg_wdata_in;
        `OFS_LINE_LEN_HI: line_len_hi_reg <= reg_wdata_in;
        `OFS_VSIZE_LO: vsize_lo_reg <= reg_wdata_in;
        `OFS_VSIZE_HI: vsize_hi_reg <= reg_wdata_in;
        `OFS_HSYNC_WIDTH: hsync_width_reg <= reg_wdata_in;
        `OFS_VSYNC_WIDTH: vsync_width_reg <= reg_wdata_in;
        `OFS_HBACK_PORCH: hback_reg <= reg_wdata_in;
        `OFS_VBACK_PORCH: vback_reg <= reg_wdata_in;
        `OFS_HFRONT_PORCH: hfront_reg <= reg_wdata_in;
        `OFS_VFRONT_PORCH: vfront_reg <= reg_wdata_in;
        `OFS_PATTERN_CTRL: test_pattern_control_reg <= reg_wdata_in;
        `OFS_IRQ_ENABLE: interrupt_output_enable_reg <= reg_wdata_in;
        `OFS_CHA_ERR_MASK: chan_a_error_mask_reg <= reg_wdata_in; // see R6
        `OFS_CHB_ERR_MASK: chan_b_error_mask_reg <= reg_wdata_in; // see R6
        default: ;
      endcase
    end
  end

  // Sticky status: an event wins over a same-cycle write-one clear,
  // so a fault landing during the clear is never lost
  always @* begin
    cha_status_next = cha_status_reg;
    chb_status_next = chb_status_reg;
    if (reg_wr_in && reg_addr_in == `OFS_CHA_ERR_STATUS) begin
      cha_status_next = cha_status_reg & ~reg_wdata_in; // see R7
    end
    if (reg_wr_in && reg_addr_in == `OFS_CHB_ERR_STATUS) begin
      chb_status_next = chb_status_reg & ~reg_wdata_in; // see R7
    end
    cha_status_next[`ERR_MSB:`ERR_LSB] = cha_status_next[`ERR_MSB:`ERR_LSB] | chan_a_err_in; // see R22
    chb_status_next[`ERR_MSB:`ERR_LSB] = chb_status_next[`ERR_MSB:`ERR_LSB] | chan_b_err_in; // see R22
    // Lock to unlock transition
    if (lock_prev_reg && !lock_lvl) begin
      cha_status_next[`BIT_PLL_UNLOCK] = 1'b1;
    end
    // Stream stop or soft reset mid-stream flags a protocol error (see R8)
    if ((stream_prev_reg && !stream_lvl) || (wr_soft_reset && stream_lvl)) begin
      cha_status_next[`BIT_LLP_ERR] = 1'b1;
      chb_status_next[`BIT_LLP_ERR] = 1'b1;
    end
    chb_status_next[1:0] = 2'b00;
    cha_status_next[1] = 1'b0;
  end

  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cha_status_reg <= `RST_CHA_STATUS;
      chb_status_reg <= `RST_ZERO;
    end else begin
      cha_status_reg <= cha_status_next;
      chb_status_reg <= chb_status_next;
    end
  end

  // Read mux; write-only and unmapped offsets read as zero
  always @* begin
    case (reg_addr_in)
      `OFS_OUT_CLK_CFG: rdata_next = output_clock_config_reg;
      `OFS_CLK_DIV_CFG: rdata_next = clock_divider_config_reg;
      `OFS_PLL_CTRL: rdata_next = pll_control_reg;
      `OFS_CHAN_CFG: rdata_next = chan_cfg_reg;
      `OFS_IN_CLK_RANGE: rdata_next = input_clock_range_reg;
      `OFS_LANE_ORDER: rdata_next = lane_order_control_reg;
      `OFS_LINE_LEN_LO: rdata_next = line_len_lo_reg;
      `OFS_LINE_LEN_HI: rdata_next = line_len_hi_reg;
      `OFS_VSIZE_LO: rdata_next = vsize_lo_reg;
      `OFS_VSIZE_HI: rdata_next = vsize_hi_reg;
      `OFS_HSYNC_WIDTH: rdata_next = hsync_width_reg;
      `OFS_VSYNC_WIDTH: rdata_next = vsync_width_reg;
      `OFS_HBACK_PORCH: rdata_next = hback_reg;
      `OFS_VBACK_PORCH: rdata_next = vback_reg;
      `OFS_HFRONT_PORCH: rdata_next = hfront_reg;
      `OFS_VFRONT_PORCH: rdata_next = vfront_reg;
      `OFS_PATTERN_CTRL: rdata_next = test_pattern_control_reg;
      `OFS_IRQ_ENABLE: rdata_next = interrupt_output_enable_reg;
      `OFS_CHA_ERR_MASK: rdata_next = chan_a_error_mask_reg;
      `OFS_CHB_ERR_MASK: rdata_next = chan_b_error_mask_reg;
      `OFS_CHA_ERR_STATUS: rdata_next = cha_status_reg;
      `OFS_CHB_ERR_STATUS: rdata_next = chb_status_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  // Read answer one cycle after the strobe
  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        reg_rdata_out <= rdata_next;
      end
    end
  end

  // Test pattern timing: active, front porch, sync, back porch (see R18)
  reg [15:0] hcount_reg;
  reg [15:0] vcount_reg;
  wire [15:0] line_len = {line_len_hi_reg, line_len_lo_reg};
  wire [15:0] vsize = {vsize_hi_reg, vsize_lo_reg};
  wire [15:0] hsync_start = line_len + {8'h00, hfront_reg};
  wire [15:0] hsync_end = hsync_start + {8'h00, hsync_width_reg};
  wire [15:0] htotal = hsync_end + {8'h00, hback_reg};
  wire [15:0] vsync_start = vsize + {8'h00, vfront_reg};
  wire [15:0] vsync_end = vsync_start + {8'h00, vsync_width_reg};
  wire [15:0] vtotal = vsync_end + {8'h00, vback_reg};
  wire pat_de = (hcount_reg < line_len) && (vcount_reg < vsize);
  wire pat_hs = (hcount_reg >= hsync_start) && (hcount_reg < hsync_end);
  wire pat_vs = (vcount_reg >= vsync_start) && (vcount_reg < vsync_end);
  wire [2:0] bar = hcount_reg[7:5];
  wire [23:0] pat_rgb = pat_de ? {{8{bar[2]}}, {8{bar[1]}}, {8{bar[0]}}} : 24'h000000;
  wire [W-1:0] pat_word = {{(W-27){1'b0}}, pat_de, pat_vs, pat_hs, pat_rgb};

  // Counters restart on soft reset; configuration stays as programmed (see R23)
  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hcount_reg <= 16'h0000;
      vcount_reg <= 16'h0000;
    end else if (soft_reset_out) begin
      hcount_reg <= 16'h0000;
      vcount_reg <= 16'h0000;
    end else if (pixel_tick && test_pattern_control_reg[`BIT_PATTERN_A]) begin
      if (hcount_reg + 16'h0001 >= htotal) begin
        hcount_reg <= 16'h0000;
        vcount_reg <= (vcount_reg + 16'h0001 >= vtotal) ? 16'h0000 : vcount_reg + 16'h0001;
      end else begin
        hcount_reg <= hcount_reg + 16'h0001;
      end
    end
  end

  // Channel routing: pattern, swap, then pin reversal
  wire [W-1:0] src_a = test_pattern_control_reg[`BIT_PATTERN_A] ? pat_word : chan_a_word_in;
  wire [W-1:0] pre_a = lane_order_control_reg[`BIT_CHAN_SWAP] ? chan_b_word_in : src_a; // see R4
  wire [W-1:0] pre_b = lane_order_control_reg[`BIT_CHAN_SWAP] ? src_a : chan_b_word_in; // see R4
  wire [W-1:0] rev_a;
  wire [W-1:0] rev_b;
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_rev
      assign rev_a[g*LANE_BITS +: LANE_BITS] = pre_a[(LANES-1-g)*LANE_BITS +: LANE_BITS];
      assign rev_b[g*LANE_BITS +: LANE_BITS] = pre_b[(LANES-1-g)*LANE_BITS +: LANE_BITS];
    end
  endgenerate

  // Output pins: idle zero unless PLL enabled and locked
  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lvds_a_out <= {W{1'b0}};
      lvds_b_out <= {W{1'b0}};
      lvds_strobe_out <= 1'b0;
    end else if (!output_live) begin
      lvds_a_out <= {W{1'b0}}; // see R24
      lvds_b_out <= {W{1'b0}};
      lvds_strobe_out <= 1'b0;
    end else begin
      lvds_a_out <= lane_order_control_reg[`BIT_A_REVERSE] ? rev_a : pre_a; // see R3
      lvds_b_out <= lane_order_control_reg[`BIT_B_REVERSE] ? rev_b : pre_b; // see R3
      lvds_strobe_out <= pixel_tick;
    end
  end

  // Control outputs and interrupt pin
  wire irq_pending = |(cha_status_reg & chan_a_error_mask_reg & 8'hFD) |
                     |(chb_status_reg & chan_b_error_mask_reg & 8'hFC);
  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pll_enable_out <= 1'b0;
      soft_reset_out <= 1'b0;
      chan_a_lane_enable_out <= 4'hF;
      out_clock_range_out <= 3'h0;
      chan_a_input_clock_range_out <= 8'h00;
      irq_out <= 1'b0;
      irq_oe_out <= 1'b0;
    end else begin
      pll_enable_out <= pll_control_reg[`BIT_PLL_EN];
      soft_reset_out <= wr_soft_reset;
      case (chan_cfg_reg[`LANES_MSB:`LANES_LSB])
        2'b00: chan_a_lane_enable_out <= 4'hF; // see R17
        2'b01: chan_a_lane_enable_out <= 4'h7;
        2'b10: chan_a_lane_enable_out <= 4'h3;
        default: chan_a_lane_enable_out <= 4'h1;
      endcase
      out_clock_range_out <= output_clock_config_reg[3:1];
      chan_a_input_clock_range_out <= input_clock_range_reg;
      // Pin floats while global enable is off (see R21)
      irq_oe_out <= interrupt_output_enable_reg[`BIT_IRQ_EN];
      irq_out <= interrupt_output_enable_reg[`BIT_IRQ_EN] & irq_pending; // see R5
    end
  end
endmodule
`default_nettype wire

// [verilog/bridge_ctrl_defines.vh]
/*
  Constants of the bridge control block: offsets, fields, resets, timing.
  Assumes inclusion by bare name from each design file that needs it.
*/
// Operation
// (R1) Host clears PLL enable, halts video, holds data lanes idle, clock lane running.
// (R2) Host resumes video, sets PLL enable, waits 3 ms, then soft reset.
// (R3) Lane-order bit 5 reverses channel A pins, bit 4 channel B.
// (R4) Lane-order bit 6 exchanges output channels A and B.
// (R5) Interrupt asserts only for an enabled error with global enable set.
// (R6) Channel A error enables in 0xE1 bits 7:2, channel B in 0xE2.
// (R7) Writing one clears a latched error bit; writing zero leaves it.
// (R8) Error bits may latch on soft reset mid-stream or when stream stops.
// (R9) Software clears latched errors before restarting a stopped stream.
// (R10) Host streams only after full configuration, else spurious errors latch.
// (R11) Continuous-clock source is divided by divider field bits 7:3.
// (R12) Divider code plus one is the ratio; 00101b divides by six.
// (R13) Software sets output-clock range bits 3:1 before enabling the PLL.
// (R14) Software sets channel A input clock range; 0x62 is 490 to 495 MHz.
// (R15) Software sets PLL enable after source, divider and ranges are set.
// (R16) Source select one takes pixel clock from channel A continuous clock.
// (R17) Lane-count code 00 enables all four channel A data lanes.
// (R18) Pattern enable makes channel A a test pattern from timing registers.
// (R19) Software sets front porches equal to the sync offsets.
// (R20) Software splits multi-byte timing values into low and high registers.
// (R21) Interrupt pin floats with global enable 0, else high when pending.
// (R22) Each channel flags sync, CRC, ECC, protocol and start-leader errors.
// (R23) Soft reset restarts datapath state, configuration registers untouched.
// (R24) Outputs stay idle while PLL is off and start only after lock.
`ifndef BRIDGE_CTRL_DEFINES_VH
`define BRIDGE_CTRL_DEFINES_VH

`define OFS_SOFT_RESET 8'h09
`define OFS_OUT_CLK_CFG 8'h0A
`define OFS_CLK_DIV_CFG 8'h0B
`define OFS_PLL_CTRL 8'h0D
`define OFS_CHAN_CFG 8'h10
`define OFS_IN_CLK_RANGE 8'h12
`define OFS_LANE_ORDER 8'h1A
`define OFS_LINE_LEN_LO 8'h20
`define OFS_LINE_LEN_HI 8'h21
`define OFS_VSIZE_LO 8'h24
`define OFS_VSIZE_HI 8'h25
`define OFS_HSYNC_WIDTH 8'h2C
`define OFS_VSYNC_WIDTH 8'h30
`define OFS_HBACK_PORCH 8'h34
`define OFS_VBACK_PORCH 8'h36
`define OFS_HFRONT_PORCH 8'h38
`define OFS_VFRONT_PORCH 8'h3A
`define OFS_PATTERN_CTRL 8'h3C
`define OFS_IRQ_ENABLE 8'hE0
`define OFS_CHA_ERR_MASK 8'hE1
`define OFS_CHB_ERR_MASK 8'hE2
`define OFS_CHA_ERR_STATUS 8'hE5
`define OFS_CHB_ERR_STATUS 8'hE6

`define BIT_SOFT_RESET 0
`define BIT_CLK_SRC_SEL 0
`define BIT_PLL_EN 0
`define BIT_A_REVERSE 5
`define BIT_B_REVERSE 4
`define BIT_CHAN_SWAP 6
`define BIT_PATTERN_A 4
`define BIT_IRQ_EN 0
`define BIT_PLL_UNLOCK 0
`define BIT_LLP_ERR 3
`define ERR_MSB 7
`define ERR_LSB 2
`define DIV_MSB 7
`define DIV_LSB 3
`define LANES_MSB 4
`define LANES_LSB 3

`define RST_ZERO 8'h00
`define RST_CHA_STATUS 8'h01

`endif

// [verilog/pixel_divider.v]
/*
  Divides a stream of source clock edges by (code + 1) into pixel ticks.
  Assumes edges arrive as one-cycle pulses on the system clock.
*/
`default_nettype none
module pixel_divider (
  input wire clk_sys_in,
  input wire nrst_in,
  input wire restart_in,
  input wire edge_in,
  input wire [4:0] ratio_code_in,
  output reg tick_out
);
  reg [4:0] count_reg;

  // Code n gives one tick every n+1 source edges (see R12)
  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count_reg <= 5'h00;
      tick_out <= 1'b0;
    end else if (restart_in) begin
      count_reg <= 5'h00;
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (edge_in) begin
        if (count_reg >= ratio_code_in) begin
          count_reg <= 5'h00;
          tick_out <= 1'b1;
        end else begin
          count_reg <= count_reg + 5'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [verilog/sync_agree.v]
/*
  Three-flop synchroniser for a pin input; the output follows only once the
  second and third flops agree.
  Assumes a single clock and an active-low asynchronous reset.
*/
`default_nettype none
module sync_agree (
  input wire clk_sys_in,
  input wire nrst_in,
  input wire async_in,
  output reg level_out
);
  reg meta_reg;
  reg s2_reg;
  reg s3_reg;

  // First flop feeds only the second; a change counts when two and three agree
  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_out <= 1'b0;
    end else begin
      meta_reg <= async_in;
      s2_reg <= meta_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_out <= s3_reg;
      end
    end
  end
endmodule
`default_nettype wire
